// *** dv/watchdog_timeout_reset_bench.sv ***
// Self-checking bench for the watchdog block.
`default_nettype none
module watchdog_timeout_reset_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, wr = 0, rd = 0, irq, rst;
  logic [3:0] a = 4'h0;
  logic [31:0] d = 32'h0, q;
  int err_count = 0, compares = 0, n;
  logic [6:0] ctl [4] = '{7'h60, 7'h24, 7'h28, 7'h21};
  watchdog_timeout_reset DUT (.core_clk_in(clk), .srst_in(srst), .addr_in(a), .wdata_in(d), .wr_in(wr),
    .rd_in(rd), .rdata_out(q), .irq_out(irq), .sys_reset_out(rst));
  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  task ck(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task acc(input logic w, input logic [3:0] ad, input logic [31:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    a <= ad;
    d <= v;
  endtask
  task idle(input int k);
    @(posedge clk);
    {wr, rd} <= 2'b0;
    repeat (k) @(posedge clk);
    #1;
  endtask
  task rdc(input logic [3:0] ad, input logic [31:0] e);
    acc(1'b0, ad, 32'h0);
    idle(0);
    ck(q === e, "read data mismatch");
  endtask
  // Every wait is bounded; running out is a mismatch and ends the run at once.
  task wt(input bit sel, input int lim);
    n = 0;
    while ((sel ? rst : irq) !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      err_count++;
      $display("CHECK FAILED %0t wait ran out", $time);
      test_done();
    end
  endtask
  task test_done;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdc(4'h0, 32'h0);
    rdc(4'h1, 32'h0);
    rdc(4'hf, 32'h0);
    acc(1'b1, 4'h0, 32'h7f);
    rdc(4'h0, 32'h7f);
    acc(1'b0, 4'h4, 32'h0);
    acc(1'b0, 4'h4, 32'h0);
    acc(1'b1, 4'h2, 32'h1);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 4'h1, 32'h3);
      acc(1'b1, 4'h0, {25'h0, ctl[i]});
      rdc(4'h1, 32'h0);
      wt(1'b0, 40000);
      ck(n + 10 > (4096 << i) && n < (4096 << i) + 6, "interrupt interval wrong");
      if (i == 0) begin
        wt(1'b1, 600);
        ck(n == 512, "reset delay window not 512 cycles");
        idle(20);
        rdc(4'h1, 32'h3);
        acc(1'b1, 4'h1, 32'h3);
        rdc(4'h1, 32'h0);
      end
    end
    acc(1'b1, 4'h2, 32'h0);
    idle(3);
    ck(irq === 1'b0, "masked interrupt still high");
    acc(1'b1, 4'h2, 32'h1);
    acc(1'b1, 4'h1, 32'h3);
    acc(1'b1, 4'h0, 32'h40);
    idle(2000);
    acc(1'b1, 4'h3, 32'h1234);
    idle(2200);
    rdc(4'h1, 32'h4);
    ck(irq === 1'b0, "interrupt with enable clear");
    acc(1'b1, 4'h3, 32'h0000a5a5);
    rdc(4'h1, 32'h0);
    idle(800);
    rdc(4'h1, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire

// *** dv/watchdog_timeout_reset_monitor.sv ***
// Port checker for the watchdog block.
`default_nettype none
module watchdog_timeout_reset_monitor (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic irq_out,
  input wire logic sys_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic [15:0] since;
  // A restart grants a full interval plus the window, so no reset may come sooner.
  always_ff @(posedge core_clk_in) begin
    if (srst_in || (wr_in && (addr_in == 4'h0 || (addr_in == 4'h3 && wdata_in == 32'h0000a5a5)))) begin
      since <= 16'h0;
    end else if (since != 16'hffff) begin
      since <= since + 16'h1;
    end
  end
  ////////////////////////////////////////
  chk_reset_spacing: assert property ($rose(sys_reset_out) |-> since > 16'h11f0)
    else $error("reset too soon after restart");
  chk_reset_pulse: assert property ($rose(sys_reset_out) |-> sys_reset_out [*8] ##1 sys_reset_out [*8] ##1 !sys_reset_out)
    else $error("reset pulse length wrong");
  chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (rd_in && addr_in > 4'h4 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_back: assert property (wr_in && addr_in == 4'h0 ##1 rd_in && addr_in == 4'h0 |=> rdata_out[6:0] == $past(wdata_in[6:0], 2))
    else $error("control readback wrong");
  chk_mask_off: assert property (wr_in && addr_in == 4'h2 && wdata_in[1:0] == 2'h0 |-> ##2 !irq_out)
    else $error("masked interrupt still high");
  // A count that reaches its terminal value between the two reads legally wraps to zero.
  chk_count_step: assert property (rd_in && addr_in == 4'h4 ##1 rd_in && addr_in == 4'h4 |=> (rdata_out[29:0] == $past(rdata_out[29:0]) + 30'h1 || rdata_out[29:0] == 30'h0))
    else $error("count did not advance by one");
  chk_status_clear: assert property (wr_in && addr_in == 4'h1 && wdata_in[1:0] == 2'h3 ##1 rd_in && addr_in == 4'h1 |=> rdata_out[1:0] == 2'h0)
    else $error("status not cleared");
endmodule
bind watchdog_timeout_reset watchdog_timeout_reset_monitor mon (.core_clk_in(core_clk_in), .srst_in(srst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .irq_out(irq_out), .sys_reset_out(sys_reset_out));
`default_nettype wire

// *** hdl/watchdog_delay_window.sv ***
// Reset delay window counter started by each interval expiry.
`default_nettype none

module watchdog_delay_window (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic cancel_in,
  output logic active_out,
  output logic done_out
);

  logic [watchdog_pkg::DELAY_W-1:0] remain;

  always_ff @(posedge core_clk_in) begin
    if (srst_in || cancel_in) begin
      remain <= '0;
      active_out <= 1'b0;
      done_out <= 1'b0;
    end else if (start_in && !active_out) begin
      remain <= watchdog_pkg::DELAY_W'(watchdog_pkg::RESET_DELAY_CYCLES - 1);
      active_out <= 1'b1;
      done_out <= 1'b0;
    end else if (active_out) begin
      if (remain == '0) begin
        active_out <= 1'b0;
        done_out <= 1'b1;
      end else begin
        remain <= remain - 1'b1;
        done_out <= 1'b0;
      end
    end else begin
      done_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** hdl/watchdog_pkg.sv ***
// Package of constants shared by the watchdog design files.
package watchdog_pkg;

  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CNT_W = 30;
  localparam int unsigned MIN_EXP = 12;
  localparam int unsigned MAX_EXP = 29;
  localparam int unsigned NORMAL_BASE_EXP = 12;
  localparam int unsigned PM_BASE_EXP = 20;
  localparam int unsigned SEL_STEP = 3;
  localparam int unsigned RESET_DELAY_CYCLES = 512;
  localparam int unsigned DELAY_W = 10;
  localparam int unsigned SYSRST_PULSE_CYCLES = 16;
  localparam int unsigned PULSE_W = 5;

  // Register map: word-indexed offsets on the plain register port.
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_RESTART = 4'h3;
  localparam logic [3:0] REG_COUNT = 4'h4;

  // Control register fields.
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_DIV_LSB = 2;
  localparam int unsigned CTRL_PM_BIT = 4;
  localparam int unsigned CTRL_IRQ_EN_BIT = 5;
  localparam int unsigned CTRL_RST_EN_BIT = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Status and mask layout.
  localparam int unsigned ST_TIMEOUT_BIT = 0;
  localparam int unsigned ST_RESET_BIT = 1;
  localparam logic [1:0] MASK_RESET = 2'h0;

  localparam logic [31:0] RESTART_KEY = 32'h0000a5a5;

endpackage

// *** hdl/watchdog_timeout_reset.sv ***
// Watchdog interval counter with timeout interrupt and delayed system reset.
//
// Notes on behaviour
// - One interval counter on the system clock times out after 2^12 up to 2^29 cycles.
// - An expiry raises the interrupt request only while the watchdog interrupt enable is set.
// - Each expiry opens a reset delay window of exactly 512 cycles and reset comes only at its end.
// - Without a restart inside the window, and only while reset enable is set, a system reset is asserted as the window ends.
// - The exponent is 12 plus divide setting plus three times select, or 20 plus three times select in PM mode.
// - The same counter feeds both the timeout event and the reset path.
`default_nettype none

module watchdog_timeout_reset (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  output logic sys_reset_out
);

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic [4:0] interval_exp(input logic [1:0] sel, input logic [1:0] div, input logic pm);
    logic [4:0] e;
    e = '0;
    if (pm) begin
      e = 5'(watchdog_pkg::PM_BASE_EXP + watchdog_pkg::SEL_STEP * sel);
    end else begin
      e = 5'(watchdog_pkg::NORMAL_BASE_EXP + div + watchdog_pkg::SEL_STEP * sel);
    end
    return e;
  endfunction

  logic [1:0] interval_select;
  logic [1:0] sysclk_divide_setting;
  logic power_manage_flag;
  logic irq_enable;
  logic reset_enable;
  logic [1:0] status;
  logic [1:0] mask;
  logic [watchdog_pkg::CNT_W-1:0] count;
  logic [watchdog_pkg::CNT_W-1:0] terminal;
  logic [4:0] exp_now;
  logic restart;
  logic expire;
  logic window_active;
  logic window_done;
  logic [watchdog_pkg::PULSE_W-1:0] pulse_left;

  wire logic wr_ctrl = wr_in && (addr_in == watchdog_pkg::REG_CTRL);
  wire logic wr_status = wr_in && (addr_in == watchdog_pkg::REG_STATUS);
  wire logic wr_mask = wr_in && (addr_in == watchdog_pkg::REG_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration. Changing the interval also restarts so a shorter setting cannot be skipped over.

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      interval_select <= watchdog_pkg::CTRL_RESET[watchdog_pkg::CTRL_SEL_LSB +: 2];
      sysclk_divide_setting <= watchdog_pkg::CTRL_RESET[watchdog_pkg::CTRL_DIV_LSB +: 2];
      power_manage_flag <= watchdog_pkg::CTRL_RESET[watchdog_pkg::CTRL_PM_BIT];
      irq_enable <= watchdog_pkg::CTRL_RESET[watchdog_pkg::CTRL_IRQ_EN_BIT];
      reset_enable <= watchdog_pkg::CTRL_RESET[watchdog_pkg::CTRL_RST_EN_BIT];
    end else if (wr_ctrl) begin
      interval_select <= wdata_in[watchdog_pkg::CTRL_SEL_LSB +: 2];
      sysclk_divide_setting <= wdata_in[watchdog_pkg::CTRL_DIV_LSB +: 2];
      power_manage_flag <= wdata_in[watchdog_pkg::CTRL_PM_BIT];
      irq_enable <= wdata_in[watchdog_pkg::CTRL_IRQ_EN_BIT];
      reset_enable <= wdata_in[watchdog_pkg::CTRL_RST_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mask <= watchdog_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask <= wdata_in[1:0];
    end
  end

  assign restart = (wr_in && (addr_in == watchdog_pkg::REG_RESTART) && (wdata_in == watchdog_pkg::RESTART_KEY))
                   || wr_ctrl;

  //////////////////////////////////////////////////////////////////////////////
  // Interval counter.

  assign exp_now = interval_exp(interval_select, sysclk_divide_setting, power_manage_flag);
  assign terminal = watchdog_pkg::CNT_W'((64'h1 << exp_now) - 64'h1);
  assign expire = (count == terminal) && !restart;

  always_ff @(posedge core_clk_in) begin
    if (srst_in || restart) begin
      count <= '0;
    end else if (count == terminal) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  watchdog_delay_window u_window (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .start_in(expire),
    .cancel_in(restart),
    .active_out(window_active),
    .done_out(window_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status; a new event beats a write-one clear in the same cycle.

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      status <= '0;
    end else begin
      status[watchdog_pkg::ST_TIMEOUT_BIT] <= (expire && irq_enable)
        || (status[watchdog_pkg::ST_TIMEOUT_BIT] && !(wr_status && wdata_in[watchdog_pkg::ST_TIMEOUT_BIT]));
      status[watchdog_pkg::ST_RESET_BIT] <= (window_done && reset_enable && !restart)
        || (status[watchdog_pkg::ST_RESET_BIT] && !(wr_status && wdata_in[watchdog_pkg::ST_RESET_BIT]));
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System reset pulse; the outer reset network is expected to return srst_in.

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pulse_left <= '0;
      sys_reset_out <= 1'b0;
    end else if (window_done && reset_enable && !restart) begin
      pulse_left <= watchdog_pkg::PULSE_W'(watchdog_pkg::SYSRST_PULSE_CYCLES - 1);
      sys_reset_out <= 1'b1;
    end else if (pulse_left != '0) begin
      pulse_left <= pulse_left - 1'b1;
    end else begin
      sys_reset_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port; data stand one cycle after the strobe, unmapped reads give zero.

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        watchdog_pkg::REG_CTRL: rdata_out <= {25'h0, reset_enable, irq_enable, power_manage_flag,
                                              sysclk_divide_setting, interval_select};
        watchdog_pkg::REG_STATUS: rdata_out <= {29'h0, window_active, status};
        watchdog_pkg::REG_MASK: rdata_out <= {30'h0, mask};
        watchdog_pkg::REG_COUNT: rdata_out <= {2'h0, count};
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

`default_nettype wire
